/* src/coincidence_trip_voter.sv */
// Four-division coincidence trip voting, seal-in and scram actuation logic.
//
// The placing of the registers and the plain strobed port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "trip_voter_params.svh"

module coincidence_trip_voter #(
  parameter logic [19:0] RESET_DELAY_CYCLES = 20'(`RESET_DELAY_CYC)
) (
  input  wire logic                              sys_clk_i,
  input  wire logic                              rst_n_i,
  input  wire trip_voter_pkg::reg_req_type       reg_req_i,
  output logic [31:0]                            reg_rdata_o,
  input  wire trip_voter_pkg::division_input_type [3:0] div_in_i,
  input  wire logic [3:0]                        nm_trip_i,
  input  wire logic [6:0]                        power_pct_i,
  input  wire trip_voter_pkg::plant_mode_type    mode_i,
  input  wire logic [1:0]                        manual_switch_i,
  output logic [3:0]                             driver_energized_o,
  output logic                                   pilot_energized_o,
  output logic                                   dump_valve_o,
  output logic                                   rod_runin_o,
  output logic                                   reset_permissive_o,
  output logic [8:0]                             status_o
);

  trip_voter_pkg::voter_state_type st;
  trip_voter_pkg::voter_state_type next;
  logic [3:0][9:0]                 dtm_flags;
  logic [3:0]                      voter_out;

  function automatic logic [2:0] count4(input logic [3:0] b);
    count4 = {2'h0, b[0]} + {2'h0, b[1]} + {2'h0, b[2]} + {2'h0, b[3]};
  endfunction

  function automatic logic at_most_one(input logic [3:0] b);
    at_most_one = (count4(b) <= 3'h1);
  endfunction

  // Any single variable with two unbypassed division flags trips the voter.
  function automatic logic vote_any(input logic [3:0][9:0] f,
                                    input logic [3:0] byp);
    logic [9:0] hit;
    logic [3:0] col;
    hit = 10'h000;
    for (int v = 0; v < 10; v++) begin
      for (int d = 0; d < 4; d++) begin
        col[d] = f[d][v] & ~byp[d];
      end
      hit[v] = (count4(col) >= 3'h2);
    end
    vote_any = |hit;
  endfunction

  function automatic logic analog_trip(input logic [11:0] val,
                                       input logic [11:0] sp,
                                       input logic high);
    analog_trip = high ? (val >= sp) : (val <= sp);
  endfunction

  // One trip module and one voting unit per division.
  for (genvar d = 0; d < 4; d++) begin : g_div
    logic [9:0] raw;
    always_comb begin
      raw = st.sample[d].discrete;
      raw[`VAR_NEUTRON] = st.nm_trip[d];
      raw[`VAR_PRESSURE] = analog_trip(st.sample[d].analog[0],
        st.setpoint[0], 1'(`ANALOG_HIGH_MASK));
      raw[`VAR_LEVEL] = analog_trip(st.sample[d].analog[1],
        st.setpoint[1], 1'b0);
      raw[`VAR_DRYWELL] = analog_trip(st.sample[d].analog[2],
        st.setpoint[2], 1'b1);
      raw[`VAR_ACCUMULATOR] = analog_trip(st.sample[d].analog[3],
        st.setpoint[3], 1'b0);
      if (st.power <= `POWER_PERMIT_PCT) begin
        raw[`VAR_STOP_VALVE] = 1'b0;
        raw[`VAR_CTRL_VALVE] = 1'b0;
      end
      if (st.mode != trip_voter_pkg::MODE_RUN) begin
        raw[`VAR_ISOLATION] = 1'b0;
      end
      // A dead or disconnected division reads as tripped on every variable.
      if (!st.sample[d].valid) begin
        raw = 10'h3FF;
      end
    end
    assign dtm_flags[d] = raw;
    assign voter_out[d] = ~st.voter_byp[d]
                          & vote_any(st.flags, st.sensor_byp);
  end

  logic       wr_ctl;
  logic       reset_req;
  logic       reset_ok;
  logic [3:0] fresh_div;
  logic [1:0] fresh_man;
  logic       fresh_cause;
  logic       cause;
  logic [3:0] sp_sel;

  always_comb begin
    next = st;
    wr_ctl = reg_req_i.wr;
    // Four division inputs per variable are expected from the sensing side.
    next.sample = div_in_i;
    next.nm_trip = nm_trip_i;
    next.power = power_pct_i;
    next.mode = mode_i;
    next.manual_sw = manual_switch_i;
    next.flags = dtm_flags;
    next.vote = voter_out;

    reset_req = wr_ctl && reg_req_i.addr == `OFS_CONTROL
                && reg_req_i.wdata[`CTRL_RESET_BIT];
    reset_ok = reset_req && st.scram == trip_voter_pkg::ST_PERMIT;
    fresh_div = st.vote | st.trip_test;
    fresh_man[0] = st.manual_sw[0]
                   || st.mode == trip_voter_pkg::MODE_SHUTDOWN;
    fresh_man[1] = st.manual_sw[1]
                   || st.mode == trip_voter_pkg::MODE_SHUTDOWN;
    fresh_cause = count4(fresh_div) >= 3'h2 || &fresh_man;
    cause = count4(st.div_trip) >= 3'h2
            || &st.manual_trip;

    // Division latches: a new trip in the reset cycle still sets.
    if (reset_ok && !fresh_cause) begin
      next.div_trip = fresh_div;
      next.manual_trip = fresh_man;
    end else begin
      next.div_trip = st.div_trip | fresh_div;
      next.manual_trip = st.manual_trip | fresh_man;
    end

    case (st.scram)
      trip_voter_pkg::ST_NORMAL: begin
        if (cause) begin
          next.scram = trip_voter_pkg::ST_SEALED;
          next.delay_cnt = 20'h00000;
        end
      end
      trip_voter_pkg::ST_SEALED: begin
        if (st.delay_cnt >= RESET_DELAY_CYCLES - 20'h00001) begin
          next.scram = trip_voter_pkg::ST_PERMIT;
        end else begin
          next.delay_cnt = st.delay_cnt + 20'h00001;
        end
      end
      trip_voter_pkg::ST_PERMIT: begin
        if (reset_ok && !fresh_cause) begin
          next.scram = trip_voter_pkg::ST_NORMAL;
        end
      end
      default: begin
        next.scram = trip_voter_pkg::ST_SEALED;
        next.delay_cnt = 20'h00000;
      end
    endcase

    // Bypass and test selections refuse more than one division.
    if (wr_ctl) begin
      if (reg_req_i.addr == `OFS_SENSOR_BYP
          || reg_req_i.addr == `OFS_VOTER_BYP
          || reg_req_i.addr == `OFS_TRIP_TEST) begin
        if (!at_most_one(reg_req_i.wdata[3:0])) begin
          next.bypass_reject = 1'b1;
        end else if (reg_req_i.addr == `OFS_SENSOR_BYP) begin
          next.sensor_byp = reg_req_i.wdata[3:0];
        end else if (reg_req_i.addr == `OFS_VOTER_BYP) begin
          next.voter_byp = reg_req_i.wdata[3:0];
        end else begin
          next.trip_test = reg_req_i.wdata[3:0];
        end
      end
      // Clearing the reject flag loses to a refusal in the same cycle.
      if (reg_req_i.addr == `OFS_ERROR && reg_req_i.wdata[0]
          && next.bypass_reject == st.bypass_reject) begin
        next.bypass_reject = 1'b0;
      end
    end
    for (int i = 0; i < 4; i++) begin
      sp_sel[i] = wr_ctl
        && reg_req_i.addr == `OFS_SETPOINT_BASE + 8'(4 * i);
      if (sp_sel[i]) begin
        next.setpoint[i] = reg_req_i.wdata[11:0];
      end
    end

    next.rdata = 32'h00000000;
    if (reg_req_i.rd) begin
      case (reg_req_i.addr)
        `OFS_SENSOR_BYP: next.rdata = {28'h0000000, st.sensor_byp};
        `OFS_VOTER_BYP:  next.rdata = {28'h0000000, st.voter_byp};
        `OFS_TRIP_TEST:  next.rdata = {28'h0000000, st.trip_test};
        `OFS_STATUS:     next.rdata = {23'h000000, st.status};
        `OFS_VAR_TRIPS:  next.rdata = {22'h000000, st.flags[0]
          | st.flags[1] | st.flags[2] | st.flags[3]};
        `OFS_ERROR:      next.rdata = {31'h00000000, st.bypass_reject};
        default: begin
          for (int i = 0; i < 4; i++) begin
            if (reg_req_i.addr == `OFS_SETPOINT_BASE + 8'(4 * i)) begin
              next.rdata = {20'h00000, st.setpoint[i]};
            end
          end
        end
      endcase
    end

    // Actuator drive: a tripped division de-energizes its load driver.
    next.driver_energized = ~next.div_trip;
    next.pilot_energized =
      next.scram == trip_voter_pkg::ST_NORMAL;
    next.dump_valve =
      next.scram != trip_voter_pkg::ST_NORMAL;
    next.rod_runin =
      next.scram != trip_voter_pkg::ST_NORMAL;
    next.permissive =
      next.scram == trip_voter_pkg::ST_PERMIT;
    // Status is a registered copy; a read at OFS_STATUS returns it.
    next.status = {|next.vote, next.scram, next.manual_trip,
                   next.div_trip};
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= '0;
      st.mode <= trip_voter_pkg::MODE_SHUTDOWN;
      st.flags <= {4{10'h3FF}};
      st.div_trip <= 4'hF;
      st.manual_trip <= 2'h3;
      st.scram <= trip_voter_pkg::ST_SEALED;
      st.setpoint <= {4{`SETPOINT_RESET}};
      st.dump_valve <= 1'b1;
      st.rod_runin <= 1'b1;
      st.status <= 9'h07F;
    end else begin
      st <= next;
    end
  end

  assign reg_rdata_o = st.rdata;
  assign driver_energized_o = st.driver_energized;
  assign pilot_energized_o = st.pilot_energized;
  assign dump_valve_o = st.dump_valve;
  assign rod_runin_o = st.rod_runin;
  assign reset_permissive_o = st.permissive;
  assign status_o = st.status;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  a_vote_two_flags: assert property (
    (st.flags[0][`VAR_PRESSURE] && st.flags[1][`VAR_PRESSURE]
     && st.sensor_byp == 4'h0 && !st.voter_byp[2]) |=> st.vote[2])
    else $error("two pressure flags did not trip voter 2");
  a_bypass_two_of_three: assert property (
    (st.sensor_byp[0] && (st.flags[1] & st.flags[2]) == 10'h000
     && (st.flags[1] & st.flags[3]) == 10'h000
     && (st.flags[2] & st.flags[3]) == 10'h000)
    |=> !st.vote[0])
    else $error("bypassed division counted in vote");
  a_two_div_scram: assert property (
    ($countones(st.div_trip) >= 2 && st.scram == trip_voter_pkg::ST_NORMAL)
    |=> ##1 !pilot_energized_o && dump_valve_o)
    else $error("two tripped divisions did not scram");
  a_manual_scram: assert property (
    (&st.manual_trip && st.scram == trip_voter_pkg::ST_NORMAL)
    |=> st.scram == trip_voter_pkg::ST_SEALED)
    else $error("manual coincidence did not scram");
  a_scram_seal_in: assert property (
    st.scram == trip_voter_pkg::ST_SEALED
    |=> st.scram != trip_voter_pkg::ST_NORMAL)
    else $error("sealed scram cleared");
  a_no_early_permit: assert property (
    (st.scram == trip_voter_pkg::ST_SEALED
     && st.delay_cnt < RESET_DELAY_CYCLES - 20'h00001)
    |=> st.scram == trip_voter_pkg::ST_SEALED && !reset_permissive_o)
    else $error("reset permitted before delay");
  a_lost_input_trip: assert property (
    !st.sample[1].valid |=> st.flags[1] == 10'h3FF)
    else $error("invalid division not tripped");
  a_single_bypass: assert property (
    $countones(st.sensor_byp) <= 1 && $countones(st.voter_byp) <= 1)
    else $error("more than one division bypassed");
  a_power_gate: assert property (
    (st.sample[0].valid && st.power <= `POWER_PERMIT_PCT)
    |=> st.flags[0][1:0] == 2'h0)
    else $error("valve trip honoured at low power");
  a_run_gate: assert property (
    (st.sample[0].valid && st.mode != trip_voter_pkg::MODE_RUN)
    |=> !st.flags[0][`VAR_ISOLATION])
    else $error("isolation trip honoured outside run");
  a_driver_off_trip: assert property (
    st.div_trip[1] |-> !driver_energized_o[1])
    else $error("tripped division still energized");
  a_dump_only_scram: assert property (
    (dump_valve_o || rod_runin_o) |-> !pilot_energized_o)
    else $error("backup scram without full scram");
  a_single_test: assert property (
    $countones(st.trip_test) <= 1)
    else $error("more than one division in test");
  a_shutdown_manual: assert property (
    st.mode == trip_voter_pkg::MODE_SHUTDOWN |=> &st.manual_trip)
    else $error("shutdown did not trip both manual systems");
  a_neutron_joins: assert property (
    st.nm_trip[3] |=> st.flags[3][`VAR_NEUTRON])
    else $error("neutron monitor trip not flagged");
  a_pressure_compare: assert property (
    (st.sample[0].analog[0] >= st.setpoint[0])
    |=> st.flags[0][`VAR_PRESSURE])
    else $error("pressure over setpoint not flagged");
  a_test_trips_division: assert property (
    st.trip_test[2] |=> st.div_trip[2])
    else $error("trip test did not trip its division");
  a_voter_bypass_quiet: assert property (
    st.voter_byp[3] |=> !st.vote[3])
    else $error("bypassed voter still voted");
  a_delay_counts: assert property (
    (st.scram == trip_voter_pkg::ST_SEALED
     && st.delay_cnt < RESET_DELAY_CYCLES - 20'h00001)
    |=> st.delay_cnt == $past(st.delay_cnt) + 20'h00001)
    else $error("reset delay counter did not advance");
  a_permit_after_delay: assert property (
    (st.scram == trip_voter_pkg::ST_SEALED
     && st.delay_cnt == RESET_DELAY_CYCLES - 20'h00001)
    |=> reset_permissive_o && st.scram == trip_voter_pkg::ST_PERMIT)
    else $error("permissive missing after delay");
  a_reset_clears: assert property (
    (st.scram == trip_voter_pkg::ST_PERMIT && reg_req_i.wr
     && reg_req_i.addr == `OFS_CONTROL
     && reg_req_i.wdata[`CTRL_RESET_BIT] && st.vote == 4'h0
     && st.trip_test == 4'h0 && st.manual_sw == 2'h0
     && st.mode != trip_voter_pkg::MODE_SHUTDOWN)
    |=> st.scram == trip_voter_pkg::ST_NORMAL && st.div_trip == 4'h0)
    else $error("valid reset did not clear the latches");

  c_auto_scram: cover property (
    st.scram == trip_voter_pkg::ST_NORMAL ##1
    st.scram == trip_voter_pkg::ST_SEALED && |st.vote);
  c_manual_scram: cover property (
    st.scram == trip_voter_pkg::ST_NORMAL && &st.manual_trip);
  c_reset_normal: cover property (
    st.scram == trip_voter_pkg::ST_PERMIT ##1
    st.scram == trip_voter_pkg::ST_NORMAL);
  c_bypass_reject: cover property ($rose(st.bypass_reject));
  c_trip_test: cover property (
    st.trip_test != 4'h0 ##1 st.div_trip != 4'h0);

endmodule // coincidence_trip_voter
`default_nettype wire

/* common/trip_voter_params.svh */
// Register offsets, field positions, reset values and timing of the voter.
`ifndef TRIP_VOTER_PARAMS_SVH
`define TRIP_VOTER_PARAMS_SVH
`define OFS_CONTROL       8'h00
`define OFS_SENSOR_BYP    8'h04
`define OFS_VOTER_BYP     8'h08
`define OFS_TRIP_TEST     8'h0C
`define OFS_SETPOINT_BASE 8'h10
`define OFS_STATUS        8'h20
`define OFS_VAR_TRIPS     8'h24
`define OFS_ERROR         8'h28
`define CTRL_RESET_BIT    0
`define VAR_STOP_VALVE    0
`define VAR_CTRL_VALVE    1
`define VAR_NEUTRON       2
`define VAR_RADIATION     3
`define VAR_PRESSURE      4
`define VAR_LEVEL         5
`define VAR_DRYWELL       6
`define VAR_ISOLATION     7
`define VAR_ACCUMULATOR   8
`define VAR_MANUAL        9
`define ANALOG_HIGH_MASK  4'h5
`define POWER_PERMIT_PCT  7'h28
`define SETPOINT_RESET    12'h800
`define RESET_DELAY_MS    10
`define CLK_MHZ           50
`define RESET_DELAY_CYC   (`RESET_DELAY_MS * 1000 * `CLK_MHZ)
`define DELAY_CNT_W       20
`endif

/* common/trip_voter_pkg.sv */
// Types shared by the coincidence trip voter and its users.
package trip_voter_pkg;
  typedef enum logic [1:0] {
    MODE_SHUTDOWN = 2'h0,
    MODE_REFUEL   = 2'h1,
    MODE_STARTUP  = 2'h2,
    MODE_RUN      = 2'h3
  } plant_mode_type;

  typedef enum logic [1:0] {
    ST_NORMAL = 2'h0,
    ST_SEALED = 2'h1,
    ST_PERMIT = 2'h3
  } scram_state_type;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_type;

  typedef struct packed {
    logic             valid;
    logic [3:0][11:0] analog;
    logic [9:0]       discrete;
  } division_input_type;

  typedef struct packed {
    division_input_type [3:0] sample;
    logic [3:0]               nm_trip;
    logic [6:0]               power;
    plant_mode_type           mode;
    logic [1:0]               manual_sw;
    logic [3:0][9:0]          flags;
    logic [3:0]               vote;
    logic [3:0]               div_trip;
    logic [1:0]               manual_trip;
    scram_state_type          scram;
    logic [19:0]              delay_cnt;
    logic [3:0]               sensor_byp;
    logic [3:0]               voter_byp;
    logic [3:0]               trip_test;
    logic [3:0][11:0]         setpoint;
    logic                     bypass_reject;
    logic [31:0]              rdata;
    logic [3:0]               driver_energized;
    logic                     pilot_energized;
    logic                     dump_valve;
    logic                     rod_runin;
    logic                     permissive;
    logic [8:0]               status;
  } voter_state_type;
endpackage

/* test/division_sensor_model.sv */
// Stand-in for the four division sensor channels that feed the voter.
`timescale 1ns/1ps
`default_nettype none

module division_sensor_model (
  input  wire logic [3:0]                          press_high_i,
  input  wire logic [3:0]                          valid_i,
  input  wire logic [3:0][9:0]                     bistable_i,
  output var  trip_voter_pkg::division_input_type [3:0] div_o
);
  always_comb begin
    for (int d = 0; d < 4; d++) begin
      // Every division supplies its own sample of every variable.
      div_o[d].valid     = valid_i[d];
      div_o[d].discrete  = bistable_i[d];
      div_o[d].analog[0] = press_high_i[d] ? 12'hF00 : 12'h100;
      div_o[d].analog[1] = 12'hF00;
      div_o[d].analog[2] = 12'h100;
      div_o[d].analog[3] = 12'hF00;
      // A dead link must not look like a frozen healthy reading.
      if (!valid_i[d]) begin
        div_o[d].analog = ~div_o[d].analog;
      end
    end
  end
endmodule // division_sensor_model

`default_nettype wire

/* test/coincidence_trip_voter_tb.sv */
// Self-checking bench for the coincidence trip voter.
`timescale 1ns/1ps
`default_nettype none
`include "trip_voter_params.svh"

module coincidence_trip_voter_tb;
  logic                                     sys_clk    = 1'b0;
  logic                                     rst_n      = 1'b0;
  trip_voter_pkg::reg_req_type              req        = '0;
  logic [31:0]                              rdata;
  trip_voter_pkg::division_input_type [3:0] div_in;
  logic [3:0]                               press_high = 4'h0;
  logic [3:0]                               valid      = 4'hF;
  logic [3:0][9:0]                          bistable   = '0;
  logic [3:0]                               nm_trip    = 4'h0;
  logic [6:0]                               power      = 7'h00;
  trip_voter_pkg::plant_mode_type           mode = trip_voter_pkg::MODE_RUN;
  logic [1:0]                               manual     = 2'h0;
  logic [3:0]                               drivers;
  logic                                     pilot;
  logic                                     dump;
  logic                                     runin;
  logic                                     permit;
  logic [8:0]                               status;
  int                                       fail_count = 0;
  int                                       n_compared = 0;

  always #10 sys_clk = ~sys_clk;

  coincidence_trip_voter #(.RESET_DELAY_CYCLES(20'h00008)) dut_u (
    .sys_clk_i(sys_clk), .rst_n_i(rst_n), .reg_req_i(req),
    .reg_rdata_o(rdata), .div_in_i(div_in), .nm_trip_i(nm_trip),
    .power_pct_i(power), .mode_i(mode), .manual_switch_i(manual),
    .driver_energized_o(drivers), .pilot_energized_o(pilot),
    .dump_valve_o(dump), .rod_runin_o(runin),
    .reset_permissive_o(permit), .status_o(status));

  division_sensor_model sensor_u (.press_high_i(press_high),
    .valid_i(valid), .bistable_i(bistable), .div_o(div_in));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask

  task automatic end_sim();
    $display("compared %0d, failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    req.wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    req.rd <= 1'b0;
    @(negedge sys_clk);
    d = rdata;
  endtask

  // Scram shows as pilot off, dump on and run-in on, all three together.
  task automatic chk_scram(input logic on, input string what);
    check(32'({pilot, dump, runin}), on ? 32'h3 : 32'h4, what);
  endtask

  task automatic set_press(input logic [3:0] v);
    @(posedge sys_clk);
    press_high <= v;
  endtask

  task automatic set_var(input int v, input logic [3:0] divs);
    @(posedge sys_clk);
    for (int d = 0; d < 4; d++) begin
      bistable[d][v] <= divs[d];
    end
  endtask

  task automatic set_quiet();
    @(posedge sys_clk);
    press_high <= 4'h0;
    valid      <= 4'hF;
    bistable   <= '0;
    nm_trip    <= 4'h0;
    power      <= 7'h00;
    mode       <= trip_voter_pkg::MODE_RUN;
    manual     <= 2'h0;
  endtask

  // Causes must be gone before the reset write, or it is refused.
  task automatic clear_scram();
    int n;
    set_quiet();
    cycles(5);
    n = 0;
    while (permit !== 1'b1 && n < 40) begin
      @(posedge sys_clk);
      n++;
    end
    check(32'(permit), 32'h1, "permissive");
    reg_write(`OFS_CONTROL, 32'h1);
    cycles(2);
    chk_scram(1'b0, "scram cleared");
    check(32'(drivers), 32'hF, "drivers restored");
  endtask

  task automatic t_vote();
    set_press(4'h1);
    cycles(6);
    check(32'({status[8], pilot}), 32'h1, "single flag");
    set_press(4'h6);
    cycles(6);
    chk_scram(1'b1, "two of four");
    check(32'(drivers), 32'h0, "drivers tripped");
    set_quiet();
    cycles(6);
    chk_scram(1'b1, "seal in");
    clear_scram();
  endtask

  task automatic t_bypass();
    logic [31:0] d;
    reg_write(`OFS_SENSOR_BYP, 32'h1);
    set_press(4'h3);
    cycles(6);
    chk_scram(1'b0, "bypassed division");
    set_press(4'h7);
    cycles(6);
    chk_scram(1'b1, "two of three");
    reg_write(`OFS_SENSOR_BYP, 32'h0);
    clear_scram();
    reg_write(`OFS_VOTER_BYP, 32'h3);
    reg_read(`OFS_VOTER_BYP, d);
    check(d, 32'h0, "double bypass");
    reg_read(`OFS_ERROR, d);
    check(d, 32'h1, "reject flag");
    reg_write(`OFS_ERROR, 32'h1);
    reg_read(`OFS_ERROR, d);
    check(d, 32'h0, "reject cleared");
    reg_write(`OFS_VOTER_BYP, 32'h8);
    set_press(4'h3);
    cycles(6);
    check(32'(drivers), 32'h8, "bypassed voter");
    chk_scram(1'b1, "three voters left");
    clear_scram();
    reg_write(`OFS_VOTER_BYP, 32'h0);
  endtask

  task automatic t_permits();
    for (int v = 0; v < 2; v++) begin
      @(posedge sys_clk);
      power <= `POWER_PERMIT_PCT;
      set_var(v, 4'h3);
      cycles(6);
      chk_scram(1'b0, "valve at threshold");
      @(posedge sys_clk);
      power <= `POWER_PERMIT_PCT + 7'h01;
      cycles(6);
      chk_scram(1'b1, "valve above threshold");
      clear_scram();
    end
    @(posedge sys_clk);
    mode <= trip_voter_pkg::MODE_STARTUP;
    set_var(`VAR_ISOLATION, 4'h3);
    cycles(6);
    chk_scram(1'b0, "isolation outside run");
    @(posedge sys_clk);
    mode <= trip_voter_pkg::MODE_RUN;
    cycles(6);
    chk_scram(1'b1, "isolation in run");
    clear_scram();
  endtask

  task automatic t_causes();
    for (int k = 0; k < 4; k++) begin
      @(posedge sys_clk);
      case (k)
        0: bistable[2][`VAR_RADIATION] <= 1'b1;
        1: bistable[1][`VAR_MANUAL] <= 1'b1;
        2: nm_trip <= 4'h9;
        default: valid <= 4'h5;
      endcase
      bistable[3][`VAR_RADIATION] <= (k == 0);
      bistable[0][`VAR_MANUAL] <= (k == 1);
      cycles(6);
      chk_scram(1'b1, "other cause");
      clear_scram();
    end
    reg_write(`OFS_SETPOINT_BASE, 32'h080);
    cycles(6);
    chk_scram(1'b1, "lowered setpoint");
    reg_write(`OFS_SETPOINT_BASE, 32'h800);
    clear_scram();
  endtask

  task automatic t_manual();
    logic [31:0] d;
    reg_write(`OFS_TRIP_TEST, 32'h4);
    cycles(6);
    check(32'(drivers), 32'hB, "trip test division");
    chk_scram(1'b0, "trip test alone");
    reg_read(`OFS_TRIP_TEST, d);
    check(d, 32'h4, "trip test readback");
    reg_write(`OFS_TRIP_TEST, 32'h0);
    @(posedge sys_clk);
    manual <= 2'h1;
    cycles(6);
    chk_scram(1'b0, "one manual system");
    @(posedge sys_clk);
    manual <= 2'h3;
    cycles(6);
    chk_scram(1'b1, "both manual systems");
    clear_scram();
    @(posedge sys_clk);
    mode <= trip_voter_pkg::MODE_SHUTDOWN;
    cycles(6);
    check(32'(status[5:4]), 32'h3, "shutdown trips manual");
    chk_scram(1'b1, "shutdown scram");
    clear_scram();
    reg_read(`OFS_SETPOINT_BASE + 8'h04, d);
    check(d, 32'h800, "setpoint reset");
    reg_read(8'h3C, d);
    check(d, 32'h0, "unmapped read");
    reg_read(`OFS_STATUS, d);
    check(d, 32'h0, "quiet status");
  endtask

  initial begin
    cycles(8);
    chk_scram(1'b1, "scram in reset");
    check(32'({drivers, status}), 32'h07F, "reset outputs");
    cycles(8);
    rst_n <= 1'b1;
    reg_write(`OFS_CONTROL, 32'h1);
    cycles(2);
    chk_scram(1'b1, "early reset refused");
    clear_scram();
    t_vote();
    t_bypass();
    t_permits();
    t_causes();
    t_manual();
    end_sim();
  end

  initial begin
    cycles(20000);
    fail_count++;
    $display("watchdog expired at %0t", $time);
    end_sim();
  end
endmodule // coincidence_trip_voter_tb

`default_nettype wire
